// file: hw/msf_pkg.sv
package msf_pkg;
	localparam int W = 32;
	localparam int AW = 4;
	localparam int ACCW = 80;
	localparam int GW = 2;
	localparam int HI_LSB = 64;
	localparam int MID_LSB = 32;
	// format bits: x signed, y signed, fractional, rounded output
	localparam int FX = 3;
	localparam int FY = 2;
	localparam int FF = 1;
	localparam int FRND = 0;
	localparam logic [3:0] FMT_SFRAC = 4'hE;
	localparam logic [3:0] FMT_SFRAC_RND = 4'hF;
	localparam logic [1:0] PART_LO = 2'h0;
	localparam logic [1:0] PART_MID = 2'h1;
	localparam logic [1:0] PART_HI = 2'h2;
	localparam logic [1:0] GRP_MX = 2'h0;
	localparam logic [1:0] GRP_MY = 2'h1;
	localparam logic [1:0] GRP_AX = 2'h2;
	localparam logic [1:0] GRP_AY = 2'h3;
	localparam logic [1:0] MM_MUL = 2'h0;
	localparam logic [1:0] MM_ADD = 2'h1;
	localparam logic [1:0] MM_SUB = 2'h2;
	localparam logic [1:0] MA_ADD = 2'h0;
	localparam logic [1:0] MA_SUB = 2'h1;
	localparam logic [1:0] MA_AVG = 2'h2;
	localparam logic [1:0] MA_ADDSUB = 2'h3;
	localparam logic [1:0] FA_ABS = 2'h0;
	localparam logic [1:0] FA_MAX = 2'h1;
	localparam logic [1:0] FA_MIN = 2'h2;
	localparam logic [1:0] FA_PASS = 2'h3;
	localparam logic [ACCW-1:0] ACC_RST = 80'h0;
	localparam logic [ACCW-1:0] RND_ONE = 80'h8000_0000;
	localparam logic [ACCW-1:0] RND_KEEP = 80'hFFFF_FFFF_FFFF_0000_0000;
	localparam logic [9:0] EXP_BIAS = 10'h07F;
	localparam logic [9:0] EXP_MAX = 10'h0FF;
	localparam logic [W-1:0] FP_INF = 32'h7F80_0000;
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_MUL = 5'h01,
		OP_MAC_ADD = 5'h02,
		OP_MAC_SUB = 5'h03,
		OP_MR_SAT = 5'h04,
		OP_MR_RND = 5'h05,
		OP_MR_CLR = 5'h06,
		OP_MR_WR = 5'h07,
		OP_MR_RD = 5'h08,
		OP_FMUL = 5'h09,
		OP_LSH = 5'h0A,
		OP_ASH = 5'h0B,
		OP_ROT = 5'h0C,
		OP_BCLR = 5'h0D,
		OP_BSET = 5'h0E,
		OP_BTGL = 5'h0F,
		OP_BTST = 5'h10,
		OP_DEPOSIT = 5'h11,
		OP_EXTRACT = 5'h12,
		OP_MF_FIX = 5'h13,
		OP_MF_FLT = 5'h14
	} msf_op_e;
endpackage

// file: hw/msf_core.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE_01 - two accumulator sets, front and back
// RULE_02 - front set readable/writable whole or by part; code moves only one part at a time via OP_MR_RD/OP_MR_WR
// RULE_03 - rounded fractional format rounds the product
// RULE_04 - one-operand ops default to signed fractional
// RULE_05 - two-operand ops default signed, signed, fractional
// RULE_06 - arithmetic shift by signed register amount
// RULE_07 - or-merge shifts keep prior destination bits
// RULE_08 - immediate deposit/extract: six-bit position, length
// RULE_09 - deposit sign option fills bits above field
// RULE_10 - extract sign option right-justifies, fills above
// RULE_11 - multifunction groups: mul 0,1; alu 2,3
// RULE_12 - accumulating multifunction uses unrounded signed fraction
// RULE_13 - multifunction alu offers halved-sum average
// RULE_14 - fixed multifunction destinations any of sixteen
// RULE_15 - float multifunction destinations independent, any
// RULE_16 - specifiers pick one of sixteen locations
// RULE_17 - clear, saturate, round accumulators in one cycle
// RULE_18 - every operation completes in one cycle
module msf_core (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire msf_pkg::msf_op_e op,
	input wire logic [3:0] fmt,
	input wire logic fmt_given,
	input wire logic to_acc,
	input wire logic acc_bk,
	input wire logic [1:0] part,
	input wire logic or_merge,
	input wire logic sign_ext,
	input wire logic imm_sel,
	input wire logic [11:0] imm,
	input wire logic [msf_pkg::AW-1:0] rx_addr,
	input wire logic [msf_pkg::AW-1:0] ry_addr,
	input wire logic [msf_pkg::AW-1:0] rn_addr,
	input wire logic [msf_pkg::GW-1:0] mx_idx,
	input wire logic [msf_pkg::GW-1:0] my_idx,
	input wire logic [msf_pkg::GW-1:0] ax_idx,
	input wire logic [msf_pkg::GW-1:0] ay_idx,
	input wire logic [msf_pkg::AW-1:0] rm_addr,
	input wire logic [msf_pkg::AW-1:0] ra_addr,
	input wire logic [msf_pkg::AW-1:0] rs_addr,
	input wire logic [1:0] mf_mul,
	input wire logic [1:0] mf_alu,
	output logic [msf_pkg::AW-1:0] rd_addr0,
	output logic [msf_pkg::AW-1:0] rd_addr1,
	output logic [msf_pkg::AW-1:0] rd_addr2,
	output logic [msf_pkg::AW-1:0] rd_addr3,
	input wire logic [msf_pkg::W-1:0] rd_data0,
	input wire logic [msf_pkg::W-1:0] rd_data1,
	input wire logic [msf_pkg::W-1:0] rd_data2,
	input wire logic [msf_pkg::W-1:0] rd_data3,
	output logic wr0_en_q,
	output logic [msf_pkg::AW-1:0] wr0_addr_q,
	output logic [msf_pkg::W-1:0] wr0_data_q,
	output logic wr1_en_q,
	output logic [msf_pkg::AW-1:0] wr1_addr_q,
	output logic [msf_pkg::W-1:0] wr1_data_q,
	output logic wr2_en_q,
	output logic [msf_pkg::AW-1:0] wr2_addr_q,
	output logic [msf_pkg::W-1:0] wr2_data_q,
	output logic btst_q
);
	localparam int W = msf_pkg::W;
	localparam int AW = msf_pkg::AW;
	localparam int ACCW = msf_pkg::ACCW;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [W-1:0] regpart(input logic [ACCW-1:0] a, input logic frac);
		regpart = frac ? a[63:32] : a[31:0];
	endfunction

	function automatic logic [ACCW-1:0] sat(input logic [ACCW-1:0] a, input logic sg,
		input logic frac);
		logic [6:0] l;
		logic [ACCW-1:0] top;
		l = frac ? 7'h3F : 7'h1F;
		sat = a;
		if (sg) begin
			top = ACCW'($signed(a) >>> l);
			if (top != '0 && top != '1) begin
				sat = a[ACCW-1] ? ({ACCW{1'b1}} << l) : ~({ACCW{1'b1}} << l);
			end
		end else begin
			top = a >> (l + 7'h01);
			if (top != '0) begin
				sat = ~({ACCW{1'b1}} << (l + 7'h01));
			end
		end
	endfunction

	// single precision, truncating; denormals flush to zero
	function automatic logic [W-1:0] fmul(input logic [W-1:0] a, input logic [W-1:0] b);
		logic [47:0] m;
		logic [9:0] e;
		logic s;
		s = a[31] ^ b[31];
		m = 48'({1'b1, a[22:0]}) * 48'({1'b1, b[22:0]});
		e = {2'h0, a[30:23]} + {2'h0, b[30:23]} - msf_pkg::EXP_BIAS;
		if (m[47]) begin
			m = m >> 1;
			e = e + 10'h001;
		end
		if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e[9] || e == 10'h000) begin
			fmul = {s, 31'h0};
		end else if (e >= msf_pkg::EXP_MAX) begin
			fmul = {s, msf_pkg::FP_INF[30:0]};
		end else begin
			fmul = {s, e[7:0], m[45:23]};
		end
	endfunction

	function automatic logic fgt(input logic [W-1:0] a, input logic [W-1:0] b);
		if (a[31] != b[31]) begin
			fgt = !a[31];
		end else begin
			fgt = a[31] ? (a[30:0] < b[30:0]) : (a[30:0] > b[30:0]);
		end
	endfunction

	// ----------------------------------------
	// operand fetch
	// ----------------------------------------
	logic mf_fix;
	logic mf_any;
	assign mf_fix = op_valid && op == msf_pkg::OP_MF_FIX;
	assign mf_any = op_valid && (op == msf_pkg::OP_MF_FIX || op == msf_pkg::OP_MF_FLT);
	// fixed register groups; only the index within the group is free
	assign rd_addr0 = mf_any ? {msf_pkg::GRP_MX, mx_idx} : rx_addr; // see RULE_11
	assign rd_addr1 = mf_any ? {msf_pkg::GRP_MY, my_idx} : ry_addr; // see RULE_11
	assign rd_addr2 = mf_any ? {msf_pkg::GRP_AX, ax_idx} : rn_addr; // see RULE_11
	assign rd_addr3 = {msf_pkg::GRP_AY, ay_idx}; // see RULE_11

	logic [32:0] sx2;
	logic [32:0] sx3;
	assign sx2 = {rd_data2[31], rd_data2};
	assign sx3 = {rd_data3[31], rd_data3};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic [ACCW-1:0] acc_q [2];
	logic [ACCW-1:0] acc_d [2];
	logic w0_en_d, w1_en_d, w2_en_d, btst_d;
	logic [AW-1:0] w0_a_d, w1_a_d, w2_a_d;
	logic [W-1:0] w0_d, w1_d, w2_d;
	logic [3:0] fm;
	logic sgn, aidx, plain, subt;
	logic [63:0] prod;
	logic [ACCW-1:0] pext, asel, sum, t;
	logic [7:0] amt, mag;
	logic [5:0] pos, len;
	logic [W-1:0] fmask, lsh, ash, rot, bm, dep, ext, sh, tmp;
	logic [32:0] s33;

	always_comb begin
		acc_d = acc_q;
		w0_en_d = 1'b0;
		w1_en_d = 1'b0;
		w2_en_d = 1'b0;
		w0_a_d = rn_addr; // see RULE_16
		w1_a_d = ra_addr;
		w2_a_d = rs_addr;
		w0_d = wr0_data_q;
		w1_d = wr1_data_q;
		w2_d = wr2_data_q;
		btst_d = btst_q;
		// missing format means signed x, signed y, fractional
		fm = fmt_given ? fmt : msf_pkg::FMT_SFRAC; // see RULE_04 see RULE_05
		if (mf_fix) begin
			fm = to_acc ? msf_pkg::FMT_SFRAC : msf_pkg::FMT_SFRAC_RND; // see RULE_12
		end
		sgn = fm[msf_pkg::FX] | fm[msf_pkg::FY];
		prod = 64'($signed({fm[msf_pkg::FX] & rd_data0[31], rd_data0})
			* $signed({fm[msf_pkg::FY] & rd_data1[31], rd_data1}));
		if (fm[msf_pkg::FF]) begin
			prod = prod << 1;
		end
		pext = {{16{sgn & prod[63]}}, prod};
		aidx = acc_bk && !mf_any; // see RULE_01
		asel = acc_q[aidx];
		plain = (op == msf_pkg::OP_MUL) || (mf_fix && mf_mul == msf_pkg::MM_MUL);
		subt = (op == msf_pkg::OP_MAC_SUB) || (mf_fix && mf_mul == msf_pkg::MM_SUB);
		sum = plain ? pext : (subt ? asel - pext : asel + pext);
		if (fm[msf_pkg::FRND]) begin
			sum = (sum + msf_pkg::RND_ONE) & msf_pkg::RND_KEEP; // see RULE_03
		end
		t = sum;
		if (op == msf_pkg::OP_MR_SAT) begin
			t = sat(asel, fm[msf_pkg::FX], fm[msf_pkg::FF]); // see RULE_17
		end else if (op == msf_pkg::OP_MR_RND) begin
			t = (asel + msf_pkg::RND_ONE) & msf_pkg::RND_KEEP; // see RULE_17
		end
		// shifter: positive amount shifts left, negative right
		amt = imm_sel ? imm[7:0] : rd_data1[7:0];
		mag = amt[7] ? 8'(8'h00 - amt) : amt;
		pos = imm_sel ? imm[5:0] : rd_data1[5:0]; // see RULE_08
		len = imm_sel ? imm[11:6] : rd_data1[11:6]; // see RULE_08
		fmask = W'((64'h1 << len) - 64'h1);
		lsh = amt[7] ? rd_data0 >> mag : rd_data0 << mag;
		ash = amt[7] ? W'($signed(rd_data0) >>> mag) : rd_data0 << mag; // see RULE_06
		rot = (rd_data0 << amt[4:0]) | (rd_data0 >> (6'h20 - {1'b0, amt[4:0]}));
		bm = 32'h1 << amt[4:0];
		dep = (rd_data0 & fmask) << pos;
		tmp = rd_data0 >> (len - 6'h01);
		if (sign_ext && len != 6'h00 && tmp[0]) begin
			dep = dep | ~W'((64'h1 << (7'(pos) + 7'(len))) - 64'h1); // see RULE_09
		end
		ext = (rd_data0 >> pos) & fmask;
		tmp = ext >> (len - 6'h01);
		if (sign_ext && len != 6'h00 && tmp[0]) begin
			ext = ext | ~fmask; // see RULE_10
		end
		case (op)
			msf_pkg::OP_LSH: sh = lsh;
			msf_pkg::OP_ASH: sh = ash;
			msf_pkg::OP_ROT: sh = rot;
			msf_pkg::OP_BCLR: sh = rd_data0 & ~bm;
			msf_pkg::OP_BSET: sh = rd_data0 | bm;
			msf_pkg::OP_BTGL: sh = rd_data0 ^ bm;
			msf_pkg::OP_DEPOSIT: sh = dep;
			default: sh = ext;
		endcase
		if (or_merge && (op == msf_pkg::OP_LSH || op == msf_pkg::OP_ASH
			|| op == msf_pkg::OP_DEPOSIT)) begin
			sh = sh | rd_data2; // see RULE_07
		end
		s33 = sx2 + sx3;
		// all results land in the flops at this edge
		if (op_valid) begin // see RULE_18
			case (op)
				msf_pkg::OP_MUL, msf_pkg::OP_MAC_ADD, msf_pkg::OP_MAC_SUB,
				msf_pkg::OP_MR_SAT, msf_pkg::OP_MR_RND: begin
					if (to_acc) begin
						acc_d[aidx] = t; // see RULE_17
					end else begin
						w0_en_d = 1'b1;
						w0_d = regpart(t, fm[msf_pkg::FF]);
					end
				end
				msf_pkg::OP_MR_CLR: acc_d[aidx] = msf_pkg::ACC_RST; // see RULE_17
				msf_pkg::OP_MR_WR: begin
					case (part)
						msf_pkg::PART_LO: acc_d[aidx][31:0] = rd_data0; // see RULE_02
						msf_pkg::PART_MID: acc_d[aidx][63:32] = rd_data0; // see RULE_02
						default: acc_d[aidx][79:64] = rd_data0[15:0]; // see RULE_02
					endcase
				end
				msf_pkg::OP_MR_RD: begin
					w0_en_d = 1'b1;
					case (part)
						msf_pkg::PART_LO: w0_d = asel[31:0]; // see RULE_02
						msf_pkg::PART_MID: w0_d = asel[63:32]; // see RULE_02
						default: w0_d = {{16{asel[79]}}, asel[79:64]};
					endcase
				end
				msf_pkg::OP_FMUL: begin
					w0_en_d = 1'b1;
					w0_d = fmul(rd_data0, rd_data1);
				end
				msf_pkg::OP_BTST: btst_d = |(rd_data0 & bm);
				msf_pkg::OP_LSH, msf_pkg::OP_ASH, msf_pkg::OP_ROT, msf_pkg::OP_BCLR,
				msf_pkg::OP_BSET, msf_pkg::OP_BTGL, msf_pkg::OP_DEPOSIT,
				msf_pkg::OP_EXTRACT: begin
					w0_en_d = 1'b1;
					w0_d = sh;
				end
				msf_pkg::OP_MF_FIX: begin
					if (to_acc) begin
						acc_d[0] = sum; // see RULE_12
					end else begin
						w0_en_d = 1'b1;
						w0_a_d = rm_addr; // see RULE_14
						w0_d = sum[63:32];
					end
					w1_en_d = 1'b1;
					w1_a_d = ra_addr; // see RULE_14
					case (mf_alu)
						msf_pkg::MA_SUB: w1_d = rd_data2 - rd_data3;
						msf_pkg::MA_AVG: w1_d = s33[32:1]; // see RULE_13
						default: w1_d = rd_data2 + rd_data3;
					endcase
					if (mf_alu == msf_pkg::MA_ADDSUB) begin
						w2_en_d = 1'b1;
						w2_d = rd_data2 - rd_data3;
					end
				end
				msf_pkg::OP_MF_FLT: begin
					w0_en_d = 1'b1;
					w0_a_d = rm_addr; // see RULE_15
					w0_d = fmul(rd_data0, rd_data1);
					w1_en_d = 1'b1;
					w1_a_d = ra_addr; // see RULE_15
					case (mf_alu)
						msf_pkg::FA_ABS: w1_d = {1'b0, rd_data2[30:0]};
						msf_pkg::FA_MAX: w1_d = fgt(rd_data2, rd_data3) ? rd_data2 : rd_data3;
						msf_pkg::FA_MIN: w1_d = fgt(rd_data2, rd_data3) ? rd_data3 : rd_data2;
						default: w1_d = rd_data2;
					endcase
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_q[0] <= msf_pkg::ACC_RST;
			acc_q[1] <= msf_pkg::ACC_RST;
			wr0_en_q <= 1'b0;
			wr1_en_q <= 1'b0;
			wr2_en_q <= 1'b0;
			wr0_addr_q <= '0;
			wr1_addr_q <= '0;
			wr2_addr_q <= '0;
			wr0_data_q <= '0;
			wr1_data_q <= '0;
			wr2_data_q <= '0;
			btst_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			wr0_en_q <= w0_en_d;
			wr1_en_q <= w1_en_d;
			wr2_en_q <= w2_en_d;
			wr0_addr_q <= w0_a_d;
			wr1_addr_q <= w1_a_d;
			wr2_addr_q <= w2_a_d;
			wr0_data_q <= w0_d;
			wr1_data_q <= w1_d;
			wr2_data_q <= w2_d;
			btst_q <= btst_d;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	acc_clear_a: assert property (op_valid && op == msf_pkg::OP_MR_CLR && !acc_bk // see RULE_17
		|=> acc_q[0] == '0) else $error("front clear missed");
	back_kept_a: assert property (op_valid && op == msf_pkg::OP_MAC_ADD && !acc_bk // see RULE_01
		|=> acc_q[1] == $past(acc_q[1])) else $error("back set disturbed");
	hi_write_a: assert property (op_valid && op == msf_pkg::OP_MR_WR && !acc_bk // see RULE_02
		&& part == msf_pkg::PART_HI |=> acc_q[0][79:64] == $past(rd_data0[15:0]))
		else $error("high part write wrong");
	one_cycle_a: assert property (op_valid && op == msf_pkg::OP_LSH // see RULE_18
		|=> wr0_en_q && wr0_addr_q == $past(rn_addr)) else $error("shift not done");
	mf_groups_a: assert property (mf_any |-> rd_addr0[3:2] == 2'h0 // see RULE_11
		&& rd_addr1[3:2] == 2'h1 && rd_addr2[3:2] == 2'h2 && rd_addr3[3:2] == 2'h3)
		else $error("group address wrong");
	mf_avg_a: assert property (mf_fix && mf_alu == msf_pkg::MA_AVG // see RULE_13
		|=> wr1_data_q == W'(($past(sx2) + $past(sx3)) >> 1)) else $error("average wrong");
	mf_dest_a: assert property (mf_fix && !to_acc |=> wr0_addr_q == $past(rm_addr) // see RULE_14
		&& wr1_addr_q == $past(ra_addr)) else $error("fixed dest wrong");
	flt_dest_a: assert property (op_valid && op == msf_pkg::OP_MF_FLT // see RULE_15
		|=> wr0_addr_q == $past(rm_addr) && wr1_addr_q == $past(ra_addr) && wr1_en_q)
		else $error("float dest wrong");
	or_merge_a: assert property (op_valid && op == msf_pkg::OP_LSH && or_merge // see RULE_07
		|=> (wr0_data_q & $past(rd_data2)) == $past(rd_data2)) else $error("merge lost bits");
	ext_sign_a: assert property (op_valid && op == msf_pkg::OP_EXTRACT && sign_ext // see RULE_10
		&& imm_sel && imm == 12'h204 |=> wr0_data_q[31:8] == {24{$past(rd_data0[11])}})
		else $error("extract sign wrong");
	ash_right_a: assert property (op_valid && op == msf_pkg::OP_ASH && imm_sel // see RULE_06
		&& imm[7:0] == 8'hFC
		|=> wr0_data_q == {{4{$past(rd_data0[31])}}, $past(rd_data0[31:4])})
		else $error("arith shift wrong");

	mf_acc_c: cover property (mf_fix && to_acc ##1 mf_fix && !to_acc);
	dep_se_c: cover property (op_valid && op == msf_pkg::OP_DEPOSIT && sign_ext && or_merge);
	sat_c: cover property (op_valid && op == msf_pkg::OP_MR_SAT ##1 wr0_en_q);
endmodule
`default_nettype wire

// file: testbench/msf_regfile.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// register file on the far side of the datapath
// ----------------------------------------
module msf_regfile (
	input wire logic clk,
	input wire logic ld_en,
	input wire logic [3:0] ld_a,
	input wire logic [31:0] ld_d,
	input wire logic [3:0][3:0] ra,
	output logic [3:0][31:0] rd,
	input wire logic [2:0] we,
	input wire logic [2:0][3:0] wa,
	input wire logic [2:0][31:0] wd
);
	logic [31:0] mem [16];

	// reads settle within the cycle so operands meet the take edge
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			rd[i] = mem[ra[i]];
		end
	end

	// the bench keeps write targets apart, so port order on a clash is moot
	always @(posedge clk) begin
		if (ld_en) begin
			mem[ld_a] <= ld_d;
		end
		for (int i = 0; i < 3; i++) begin
			if (we[i]) begin
				mem[wa[i]] <= wd[i];
			end
		end
	end
endmodule
`default_nettype wire

// file: testbench/tb_msf_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_msf_core;
	// ----------------------------------------
	// stimulus, mirror and result queues
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst_n, op_valid, fmt_given, to_acc, acc_bk, or_merge, sign_ext, imm_sel, ld_en;
	msf_pkg::msf_op_e op;
	logic [3:0] fmt, rx_addr, ry_addr, rn_addr, rm_addr, ra_addr, rs_addr, ld_a;
	logic [1:0] part, mx_idx, my_idx, ax_idx, ay_idx, mf_mul, mf_alu;
	logic [11:0] imm;
	logic [31:0] ld_d, seed, a, b, r;
	logic [32:0] sum;
	logic [79:0] pr;
	logic [3:0] rd_addr0, rd_addr1, rd_addr2, rd_addr3, wr0_addr_q, wr1_addr_q, wr2_addr_q;
	logic [3:0][31:0] rdd;
	logic wr0_en_q, wr1_en_q, wr2_en_q, btst_q;
	logic [31:0] wr0_data_q, wr1_data_q, wr2_data_q;
	logic [31:0] rf [16];
	logic [79:0] acc [2];
	logic [51:0] q [3][$];
	int cyc = 0;
	int fails = 0;
	int num_checks = 0;
	int pp [4] = '{0, 4, 26, 31};
	int ll [4] = '{32, 8, 6, 1};

	always #25 clk = ~clk;

	msf_core msf_core_inst (
		.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op(op), .fmt(fmt),
		.fmt_given(fmt_given), .to_acc(to_acc), .acc_bk(acc_bk), .part(part),
		.or_merge(or_merge), .sign_ext(sign_ext), .imm_sel(imm_sel), .imm(imm),
		.rx_addr(rx_addr), .ry_addr(ry_addr), .rn_addr(rn_addr), .mx_idx(mx_idx),
		.my_idx(my_idx), .ax_idx(ax_idx), .ay_idx(ay_idx), .rm_addr(rm_addr),
		.ra_addr(ra_addr), .rs_addr(rs_addr), .mf_mul(mf_mul), .mf_alu(mf_alu),
		.rd_addr0(rd_addr0), .rd_addr1(rd_addr1), .rd_addr2(rd_addr2), .rd_addr3(rd_addr3),
		.rd_data0(rdd[0]), .rd_data1(rdd[1]), .rd_data2(rdd[2]), .rd_data3(rdd[3]),
		.wr0_en_q(wr0_en_q), .wr0_addr_q(wr0_addr_q), .wr0_data_q(wr0_data_q),
		.wr1_en_q(wr1_en_q), .wr1_addr_q(wr1_addr_q), .wr1_data_q(wr1_data_q),
		.wr2_en_q(wr2_en_q), .wr2_addr_q(wr2_addr_q), .wr2_data_q(wr2_data_q),
		.btst_q(btst_q)
	);

	msf_regfile msf_regfile_inst (
		.clk(clk), .ld_en(ld_en), .ld_a(ld_a), .ld_d(ld_d),
		.ra({rd_addr3, rd_addr2, rd_addr1, rd_addr0}), .rd(rdd),
		.we({wr2_en_q, wr1_en_q, wr0_en_q}), .wa({wr2_addr_q, wr1_addr_q, wr0_addr_q}),
		.wd({wr2_data_q, wr1_data_q, wr0_data_q})
	);

	// ----------------------------------------
	// reference arithmetic
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
	endfunction

	function automatic logic [31:0] shf(input logic [31:0] v, input logic [7:0] n, input logic ar);
		int s;
		s = $signed(n);
		if (s >= 0) return (s >= 32) ? 32'h0000_0000 : v << s;
		if (-s >= 32) return (ar && v[31]) ? 32'hFFFF_FFFF : 32'h0000_0000;
		if (ar) return $signed(v) >>> -s;
		return v >> -s;
	endfunction

	function automatic logic [31:0] fld(input logic [31:0] v, input int p, input int l,
			input logic ext, input logic se);
		logic [63:0] m, f, t;
		m = (64'h1 << l) - 64'h1;
		f = ext ? ({32'h0, v} >> p) & m : {32'h0, v} & m;
		t = ext ? f : f << p;
		if (se && l > 0 && f[l-1]) t = t | ~((64'h1 << (ext ? l : p + l)) - 64'h1);
		return t[31:0];
	endfunction

	// signed fractional product, already aligned as the accumulator holds it
	function automatic logic [79:0] prd(input logic [31:0] x, input logic [31:0] y);
		logic [63:0] p;
		p = $signed({{32{x[31]}}, x}) * $signed({{32{y[31]}}, y});
		return {{15{p[63]}}, p, 1'b0};
	endfunction

	function automatic logic [31:0] frac(input logic [79:0] v, input logic rnd);
		logic [79:0] t;
		t = rnd ? v + msf_pkg::RND_ONE : v;
		return t[63:32];
	endfunction

	// ----------------------------------------
	// drivers, checking and closing
	// ----------------------------------------
	task automatic chk(input logic [51:0] got, input logic [51:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// stamp is the take edge: the write pulse stands right after it
	task automatic ex(input int p, input logic [3:0] ad, input logic [31:0] d);
		q[p].push_back({16'(cyc + 1), ad, d});
		rf[ad] = d;
	endtask

	task automatic pop(input int p, input logic [35:0] got);
		if (q[p].size() == 0) begin
			chk({16'(cyc), got}, 52'h0);
		end else begin
			chk({16'(cyc), got}, q[p].pop_front());
		end
	endtask

	task automatic go(input msf_pkg::msf_op_e o, input logic [3:0] x, input logic [3:0] y,
			input logic [3:0] n, input logic s, input logic [11:0] im);
		op = o;
		rx_addr = x;
		ry_addr = y;
		rn_addr = n;
		imm_sel = s;
		imm = im;
		op_valid = 1'b1;
		@(posedge clk);
		#2;
	endtask

	task automatic ld(input logic [3:0] ad, input logic [31:0] d);
		ld_en = 1'b1;
		ld_a = ad;
		ld_d = d;
		rf[ad] = d;
		@(posedge clk);
		#2;
	endtask

	task automatic idle();
		op_valid = 1'b0;
		ld_en = 1'b0;
		repeat (2) @(posedge clk);
		#2;
	endtask

	always @(posedge clk) begin
		cyc++;
		#1;
		if (wr0_en_q === 1'b1) begin
			pop(0, {wr0_addr_q, wr0_data_q});
		end
		if (wr1_en_q === 1'b1) begin
			pop(1, {wr1_addr_q, wr1_data_q});
		end
		if (wr2_en_q === 1'b1) begin
			pop(2, {wr2_addr_q, wr2_data_q});
		end
	end

	// about 115 cycles of traffic; 3000 cycles, some twenty-six times that, means a hang
	initial begin
		#150000;
		fails++;
		wrap_up();
	end

	initial begin
		rst_n = 1'b0;
		{op_valid, fmt_given, to_acc, acc_bk, or_merge, sign_ext, imm_sel, ld_en} = 8'h00;
		op = msf_pkg::OP_NOP;
		{fmt, rx_addr, ry_addr, rn_addr, rm_addr, ra_addr, rs_addr, ld_a} = 32'h0;
		{part, mx_idx, my_idx, ax_idx, ay_idx, mf_mul, mf_alu} = 14'h0;
		imm = 12'h000;
		ld_d = 32'h0000_0000;
		seed = 32'h0001_5424;
		acc[0] = 80'h0;
		acc[1] = 80'h0;
		for (int i = 0; i < 16; i++) begin
			if (i == 12) begin
				rst_n = 1'b1;
			end
			seed = lfsr(seed);
			ld(4'(i), i == 15 ? 32'hFFFF_FFF8 : i == 14 ? 32'h8421_F0F0 : seed & 32'h7FFF_FFFF);
		end
		idle();
		chk(52'({wr0_en_q, wr1_en_q, wr2_en_q, btst_q, wr0_data_q}), 52'h0);
		ex(0, 4'h3, shf(rf[14], 8'h04, 1'b0));
		go(msf_pkg::OP_LSH, 4'hE, 4'h0, 4'h3, 1'b1, 12'h004);
		ex(0, 4'h4, shf(rf[14], 8'hFC, 1'b1));
		go(msf_pkg::OP_ASH, 4'hE, 4'h0, 4'h4, 1'b1, 12'h0FC);
		ex(0, 4'h5, shf(rf[14], rf[15][7:0], 1'b1));
		go(msf_pkg::OP_ASH, 4'hE, 4'hF, 4'h5, 1'b0, 12'h000);
		ex(0, 4'h6, shf(rf[14], 8'hE0, 1'b1));
		go(msf_pkg::OP_ASH, 4'hE, 4'h0, 4'h6, 1'b1, 12'h0E0);
		ex(0, 4'h7, (rf[14] << 5) | (rf[14] >> 27));
		go(msf_pkg::OP_ROT, 4'hE, 4'h0, 4'h7, 1'b1, 12'h005);
		go(msf_pkg::OP_BTST, 4'hE, 4'h0, 4'h0, 1'b1, 12'h005);
		chk(52'(btst_q), 52'(rf[14][5]));
		go(msf_pkg::OP_BTST, 4'hE, 4'h0, 4'h0, 1'b1, 12'h003);
		chk(52'(btst_q), 52'(rf[14][3]));
		idle();
		or_merge = 1'b1;
		ex(0, 4'h3, rf[3] | shf(rf[14], 8'h02, 1'b0));
		go(msf_pkg::OP_LSH, 4'hE, 4'h0, 4'h3, 1'b1, 12'h002);
		ex(0, 4'h4, rf[4] | fld(rf[14], 8, 6, 1'b0, 1'b0));
		go(msf_pkg::OP_DEPOSIT, 4'hE, 4'h0, 4'h4, 1'b1, {6'h06, 6'h08});
		or_merge = 1'b0;
		for (int k = 0; k < 16; k++) begin
			sign_ext = k[3];
			ex(0, 4'(k[2:0]), fld(rf[14], pp[k % 4], ll[k % 4], k[2], k[3]));
			go(k[2] ? msf_pkg::OP_EXTRACT : msf_pkg::OP_DEPOSIT, 4'hE, 4'h0, 4'(k[2:0]), 1'b1,
				{6'(ll[k % 4]), 6'(pp[k % 4])});
		end
		sign_ext = 1'b0;
		ex(0, 4'h8, frac(prd(rf[9], rf[10]), 1'b0));
		go(msf_pkg::OP_MUL, 4'h9, 4'hA, 4'h8, 1'b0, 12'h000);
		fmt_given = 1'b1;
		fmt = msf_pkg::FMT_SFRAC_RND;
		ex(0, 4'hB, frac(prd(rf[9], rf[10]), 1'b1));
		go(msf_pkg::OP_MUL, 4'h9, 4'hA, 4'hB, 1'b0, 12'h000);
		fmt_given = 1'b0;
		to_acc = 1'b1;
		acc[0] = acc[0] + prd(rf[1], rf[2]);
		go(msf_pkg::OP_MAC_ADD, 4'h1, 4'h2, 4'h0, 1'b0, 12'h000);
		acc[0] = acc[0] + prd(rf[3], rf[5]);
		go(msf_pkg::OP_MAC_ADD, 4'h3, 4'h5, 4'h0, 1'b0, 12'h000);
		acc_bk = 1'b1;
		acc[1] = acc[1] - prd(rf[1], rf[2]);
		go(msf_pkg::OP_MAC_SUB, 4'h1, 4'h2, 4'h0, 1'b0, 12'h000);
		to_acc = 1'b0;
		part = msf_pkg::PART_MID;
		ex(0, 4'h9, acc[1][63:32]);
		go(msf_pkg::OP_MR_RD, 4'h0, 4'h0, 4'h9, 1'b0, 12'h000);
		acc_bk = 1'b0;
		ex(0, 4'hA, acc[0][63:32]);
		go(msf_pkg::OP_MR_RD, 4'h0, 4'h0, 4'hA, 1'b0, 12'h000);
		part = msf_pkg::PART_LO;
		ex(0, 4'hC, acc[0][31:0]);
		go(msf_pkg::OP_MR_RD, 4'h0, 4'h0, 4'hC, 1'b0, 12'h000);
		ex(0, 4'hD, frac(acc[0], 1'b1));
		go(msf_pkg::OP_MR_RND, 4'h0, 4'h0, 4'hD, 1'b0, 12'h000);
		acc[0] = 80'h0;
		go(msf_pkg::OP_MR_CLR, 4'h0, 4'h0, 4'h0, 1'b0, 12'h000);
		part = msf_pkg::PART_MID;
		ex(0, 4'h9, 32'h0000_0000);
		go(msf_pkg::OP_MR_RD, 4'h0, 4'h0, 4'h9, 1'b0, 12'h000);
		part = msf_pkg::PART_HI;
		acc[0][79:64] = rf[14][15:0];
		go(msf_pkg::OP_MR_WR, 4'hE, 4'h0, 4'h0, 1'b0, 12'h000);
		ex(0, 4'h9, {{16{rf[14][15]}}, rf[14][15:0]});
		go(msf_pkg::OP_MR_RD, 4'h0, 4'h0, 4'h9, 1'b0, 12'h000);
		idle();
		// alu groups stay positive so the halved sum needs no sign guess
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			ld(4'(i), seed & 32'h3FFF_FFFF);
		end
		idle();
		for (int k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			{mx_idx, my_idx, ax_idx, ay_idx} = seed[7:0];
			rm_addr = {1'b0, seed[10:8]};
			ra_addr = {1'b0, seed[10:8] + 3'h1};
			rs_addr = {1'b0, seed[10:8] + 3'h2};
			mf_alu = k[1:0];
			mf_mul = {1'b0, k[2]};
			a = rf[{2'h2, ax_idx}];
			b = rf[{2'h3, ay_idx}];
			pr = prd(rf[{2'h0, mx_idx}], rf[{2'h1, my_idx}]);
			sum = {a[31], a} + {b[31], b};
			r = k[1:0] == 2'h1 ? a - b : k[1:0] == 2'h2 ? sum[32:1] : a + b;
			ex(0, rm_addr, frac(k[2] ? acc[0] + pr : pr, 1'b1));
			ex(1, ra_addr, r);
			if (k[1:0] == 2'h3) begin
				ex(2, rs_addr, a - b);
			end
			go(msf_pkg::OP_MF_FIX, 4'h0, 4'h0, 4'h0, 1'b0, 12'h000);
			idle();
		end
		to_acc = 1'b1;
		mf_mul = 2'h1;
		mf_alu = msf_pkg::MA_ADD;
		ra_addr = 4'hC;
		acc[0] = acc[0] + prd(rf[{2'h0, mx_idx}], rf[{2'h1, my_idx}]);
		ex(1, 4'hC, rf[{2'h2, ax_idx}] + rf[{2'h3, ay_idx}]);
		go(msf_pkg::OP_MF_FIX, 4'h0, 4'h0, 4'h0, 1'b0, 12'h000);
		to_acc = 1'b0;
		part = msf_pkg::PART_LO;
		ex(0, 4'h7, acc[0][31:0]);
		go(msf_pkg::OP_MR_RD, 4'h0, 4'h0, 4'h7, 1'b0, 12'h000);
		// front set has a negative high part here, far below the fraction range
		ex(0, 4'h6, 32'h8000_0000);
		go(msf_pkg::OP_MR_SAT, 4'h0, 4'h0, 4'h6, 1'b0, 12'h000);
		idle();
		ld(4'h0, 32'h3F80_0000);
		ld(4'h4, 32'h4000_0000);
		ld(4'h8, 32'hC040_0000);
		idle();
		{mx_idx, my_idx, ax_idx} = 6'h00;
		mf_mul = 2'h0;
		mf_alu = msf_pkg::FA_ABS;
		rm_addr = 4'hF;
		ra_addr = 4'h3;
		ex(0, 4'hF, 32'h4000_0000);
		ex(1, 4'h3, 32'h4040_0000);
		go(msf_pkg::OP_MF_FLT, 4'h0, 4'h0, 4'h0, 1'b0, 12'h000);
		idle();
		chk(52'(q[0].size() + q[1].size() + q[2].size()), 52'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
